//--- pkg/mbspi_pkg.sv
`default_nettype none
package mbspi_pkg;
   // buffer and data path
   localparam int NUM_ENTRIES = 256;
   localparam int ADDR_W      = 8;
   localparam int WORD_W      = 16;
   localparam int FIFO_DEPTH  = 16;
   localparam int NUM_FMT     = 2;
   localparam int LEN_MIN     = 2;
   localparam int LEN_MAX     = 16;
   // setting field positions
   localparam int GCR_CTRL_BIT  = 0;
   localparam int FMT_LEN_LSB   = 0;
   localparam int FMT_PS_LSB    = 8;
   localparam int FMT_PHASE_BIT = 16;
   localparam int FMT_POL_BIT   = 17;
   localparam int DLY_T2C_LSB   = 0;
   localparam int DLY_C2T_LSB   = 8;
   // buffer entry control and status fields
   localparam int CTL_FMT_BIT   = 0;
   localparam int CTL_HOLD_BIT  = 1;
   localparam int STS_DONE_BIT  = 0;
   localparam int STS_ABORT_BIT = 1;
   // pin indices
   localparam int NUM_PINS = 4;
   localparam int PIN_SCLK = 0;
   localparam int PIN_SIMO = 1;
   localparam int PIN_SOMI = 2;
   localparam int PIN_CS   = 3;
   // select timing extras, in clock cycles
   localparam int SETUP_ADD      = 2;
   localparam int SETUP_ADD_HOLD = 3;
   localparam int HOLD_ADD       = 1;
   // serial clock limits
   localparam int CLK_PERIOD_PS      = 5000;
   localparam int MIN_SCLK_PERIOD_PS = 25000;
   localparam int MIN_SCLK_CYC = (MIN_SCLK_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [15:0] RST_WORD = 16'h0000;

   typedef struct packed {
      logic [ADDR_W-1:0] idx;
      logic [15:0]       ctrl;
      logic [15:0]       tx;
   } mbspi_item_s;
   localparam int ITEM_W = $bits(mbspi_item_s);

   // serial clock period in mclk cycles from the prescale field
   function automatic logic [8:0] sclkPeriod(input logic [7:0] ps);
      logic [8:0] p;
      p = (ps == 8'h00) ? 9'h002 : {1'b0, ps} + 9'h001;
      if (p < 9'(MIN_SCLK_CYC)) p = 9'(MIN_SCLK_CYC);
      return p;
   endfunction

   // word length clamped to the legal range
   function automatic logic [4:0] fmtLen(input logic [4:0] f);
      logic [4:0] l;
      l = f;
      if (l < 5'(LEN_MIN)) l = 5'(LEN_MIN);
      if (l > 5'(LEN_MAX)) l = 5'(LEN_MAX);
      return l;
   endfunction
endpackage
`default_nettype wire

//--- pkg/mbspi_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mbspi_stream_if #(parameter int W = 8) ();
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- design/mbspi_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module mbspi_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic    mclk,
   input wire logic    rst,
   // fill side
   mbspi_stream_if.snk inp,
   // drain side
   mbspi_stream_if.src outp
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr;
   logic [AW:0]      rdPtr;
   logic             full;
   logic             empty;

   assign empty = (wrPtr == rdPtr);
   assign full  = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
   assign inp.ready  = !full;
   assign outp.valid = !empty;
   assign outp.data  = mem[rdPtr[AW-1:0]];

   always_ff @(posedge mclk) begin
      if (inp.valid && !full) mem[wrPtr[AW-1:0]] <= inp.data;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) wrPtr <= '0;
      else if (inp.valid && !full) wrPtr <= wrPtr + 1'b1;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) rdPtr <= '0;
      else if (outp.ready && !empty) rdPtr <= rdPtr + 1'b1;
   end
endmodule
`default_nettype wire

//--- design/mbspi_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - words of 2 to 16 bits shift
// - controller drives clock, peripheral follows it
// - prescale sets the bit rate
// - every word picks its own format
// - unused pins become software controlled IO
// - 256 entries of tx, rx, control, status
// - groups walk consecutive buffer entries
// - select to first edge: delay plus 2/3
// - last edge to deselect: half plus delay+1
// - clock halves equal or first half one longer, idle level from format 0 polarity
// - out data valid before capture edge
// - input sampled on the capture edge
// - period prescale+1, never under 25 ns
// - mode, phase and polarity bit positions
// - select delays in their own setting
module mbspi_ctrl import mbspi_pkg::*; (
   // clock and reset
   input  wire logic                    mclk,
   input  wire logic                    rst,
   // settings
   input  wire logic [15:0]             globalControlSetting,
   input  wire logic [NUM_FMT-1:0][31:0] wordFormatSetting,
   input  wire logic [15:0]             selectDelaySetting,
   // buffer access
   input  wire logic                    bufWrEn,
   input  wire logic [ADDR_W-1:0]       bufWrAddr,
   input  wire logic [15:0]             bufWrTx,
   input  wire logic [15:0]             bufWrCtrl,
   input  wire logic [ADDR_W-1:0]       bufRdAddr,
   output logic      [63:0]             bufRdData,
   // transfer group
   input  wire logic                    groupStart,
   input  wire logic [ADDR_W-1:0]       groupFirst,
   input  wire logic [ADDR_W-1:0]       groupLast,
   output logic                         busy,
   // general purpose pin use
   input  wire logic [NUM_PINS-1:0]     pinGpio,
   input  wire logic [NUM_PINS-1:0]     gpioOutVal,
   input  wire logic [NUM_PINS-1:0]     gpioOutEn,
   output logic      [NUM_PINS-1:0]     gpioIn,
   // serial pins
   input  wire logic                    serialClockPinIn,
   output logic                         serialClockPinOut,
   output logic                         serialClockPinOe,
   input  wire logic                    controllerOutDataPinIn,
   output logic                         controllerOutDataPinOut,
   output logic                         controllerOutDataPinOe,
   input  wire logic                    controllerInDataPinIn,
   output logic                         controllerInDataPinOut,
   output logic                         controllerInDataPinOe,
   input  wire logic                    chipSelNPinIn,
   output logic                         chipSelNPinOut,
   output logic                         chipSelNPinOe
);
   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_SHIFT, ST_HOLD} mbspi_state_e;

   mbspi_state_e       st;
   logic [15:0]        txMem   [NUM_ENTRIES];
   logic [15:0]        rxMem   [NUM_ENTRIES];
   logic [15:0]        ctrlMem [NUM_ENTRIES];
   logic [15:0]        stsMem  [NUM_ENTRIES];
   logic [NUM_PINS-1:0] pinIn, pinMeta, pinSync, pinOut, pinOe, funcOut, funcOe;
   logic               seqActive;
   logic [ADDR_W-1:0]  seqIdx, seqEnd, curIdx;
   logic [31:0]        curFmt, newFmt;
   logic [7:0]         curC2t, curT2c;
   logic               curHold, csActive, sclkLvl, sclkPrevRaw, firstEdge;
   logic [9:0]         cnt;
   logic [15:0]        shreg, rxShift;
   logic [4:0]         bitCnt, nextBits, curLen, newLen;
   logic [8:0]         per, halfLo, halfHi;
   logic               ctrlMode, phase, pol, inBit, csInAct, sclkRel, load;
   logic               mEdge, sEdge, edgeNow, edgeLead, isCapture, isLaunch, wordEnd;
   logic               wbEn, wbAbort;
   mbspi_item_s        popItem;

   mbspi_stream_if #(.W(ITEM_W)) pushIf ();
   mbspi_stream_if #(.W(ITEM_W)) popIf ();

   mbspi_fifo #(.WIDTH(ITEM_W), .DEPTH(FIFO_DEPTH)) mbspi_fifo_inst (
      .mclk (mclk),
      .rst  (rst),
      .inp  (pushIf),
      .outp (popIf)
   );

   assign ctrlMode = globalControlSetting[GCR_CTRL_BIT];
   assign phase    = curFmt[FMT_PHASE_BIT];
   assign pol      = curFmt[FMT_POL_BIT];
   assign curLen   = fmtLen(curFmt[FMT_LEN_LSB +: 5]);
   assign per      = sclkPeriod(curFmt[FMT_PS_LSB +: 8]);
   assign halfLo   = {1'b0, per[8:1]};
   assign halfHi   = per - halfLo;

   assign popItem     = popIf.data;
   assign popIf.ready = (st == ST_IDLE);
   assign load        = popIf.valid && (st == ST_IDLE);
   assign newFmt = wordFormatSetting[popItem.ctrl[CTL_FMT_BIT]];
   assign newLen = fmtLen(newFmt[FMT_LEN_LSB +: 5]);

   assign pushIf.valid = seqActive;
   assign pushIf.data  = {seqIdx, ctrlMem[seqIdx], txMem[seqIdx]};

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         seqActive <= 1'b0;
         seqIdx    <= '0;
         seqEnd    <= '0;
      end else if (!seqActive) begin
         if (groupStart) begin
            seqActive <= 1'b1;
            seqIdx    <= groupFirst;
            seqEnd    <= groupLast;
         end
      end else if (pushIf.ready) begin
         if (seqIdx == seqEnd) seqActive <= 1'b0;
         else seqIdx <= seqIdx + 8'h01;
      end
   end

   always_ff @(posedge mclk) begin
      if (bufWrEn) begin
         txMem[bufWrAddr]   <= bufWrTx;
         ctrlMem[bufWrAddr] <= bufWrCtrl;
      end
      if (wbEn) rxMem[curIdx] <= rxShift;
   end

   // status: completion set wins over a software rewrite
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NUM_ENTRIES; i++) stsMem[i] <= RST_WORD;
      end else begin
         if (bufWrEn) stsMem[bufWrAddr] <= RST_WORD;
         if (wbEn) begin
            stsMem[curIdx]                <= RST_WORD;
            stsMem[curIdx][STS_DONE_BIT]  <= !wbAbort;
            stsMem[curIdx][STS_ABORT_BIT] <= wbAbort;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) bufRdData <= '0;
      else bufRdData <= {stsMem[bufRdAddr], ctrlMem[bufRdAddr],
                         rxMem[bufRdAddr], txMem[bufRdAddr]};
   end

   // pin input synchronisers
   assign pinIn = {chipSelNPinIn, controllerInDataPinIn, controllerOutDataPinIn,
                   serialClockPinIn};
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pinMeta     <= '0;
         pinSync     <= '0;
         gpioIn      <= '0;
         sclkPrevRaw <= 1'b0;
      end else begin
         pinMeta     <= pinIn;
         pinSync     <= pinMeta;
         gpioIn      <= pinSync;
         sclkPrevRaw <= pinSync[PIN_SCLK];
      end
   end
   assign csInAct = !pinSync[PIN_CS];
   assign sclkRel = pinSync[PIN_SCLK] ^ pol;
   assign inBit   = ctrlMode ? pinSync[PIN_SOMI] : pinSync[PIN_SIMO];

   always_comb begin
      mEdge     = ctrlMode && (st == ST_SETUP || st == ST_SHIFT) && (cnt == 10'd1);
      sEdge     = !ctrlMode && (st == ST_SHIFT) && csInAct &&
                  (pinSync[PIN_SCLK] != sclkPrevRaw);
      edgeNow   = mEdge || sEdge;
      edgeLead  = ctrlMode ? !sclkLvl : sclkRel;
      isCapture = edgeNow && (edgeLead == phase);
      isLaunch  = edgeNow && (edgeLead != phase) && !firstEdge;
      nextBits  = bitCnt + 5'(isCapture);
      wordEnd   = edgeNow && !edgeLead && (nextBits == curLen);
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         shreg     <= '0;
         rxShift   <= '0;
         bitCnt    <= '0;
         firstEdge <= 1'b1;
      end else if (load) begin
         shreg     <= popItem.tx << (5'(LEN_MAX) - newLen);
         rxShift   <= '0;
         bitCnt    <= '0;
         firstEdge <= 1'b1;
      end else begin
         if (edgeNow) firstEdge <= 1'b0;
         if (isCapture) begin
            rxShift <= {rxShift[14:0], inBit};
            bitCnt  <= nextBits;
         end
         if (isLaunch) shreg <= {shreg[14:0], 1'b0};
      end
   end

   // sequencing of select, clock and write-back
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st       <= ST_IDLE;
         cnt      <= '0;
         csActive <= 1'b0;
         sclkLvl  <= 1'b0;
         curIdx   <= '0;
         curFmt   <= '0;
         curHold  <= 1'b0;
         curC2t   <= '0;
         curT2c   <= '0;
         wbEn     <= 1'b0;
         wbAbort  <= 1'b0;
         busy     <= 1'b0;
      end else begin
         wbEn <= 1'b0;
         busy <= seqActive || popIf.valid || (st != ST_IDLE);
         case (st)
            ST_IDLE: begin
               sclkLvl <= 1'b0;
               if (load) begin
                  curIdx  <= popItem.idx;
                  curFmt  <= newFmt;
                  curHold <= popItem.ctrl[CTL_HOLD_BIT];
                  curC2t  <= selectDelaySetting[DLY_C2T_LSB +: 8];
                  curT2c  <= selectDelaySetting[DLY_T2C_LSB +: 8];
                  wbAbort <= 1'b0;
                  if (ctrlMode) begin
                     csActive <= 1'b1;
                     cnt <= 10'(selectDelaySetting[DLY_C2T_LSB +: 8]) +
                            (popItem.ctrl[CTL_HOLD_BIT] ? 10'(SETUP_ADD_HOLD)
                                                        : 10'(SETUP_ADD));
                     st  <= ST_SETUP;
                  end else begin
                     st <= ST_SHIFT;
                  end
               end else if (!seqActive) begin
                  csActive <= 1'b0;
               end
            end
            ST_SETUP: begin
               if (mEdge) begin
                  sclkLvl <= 1'b1;
                  cnt     <= 10'(halfHi);
                  st      <= ST_SHIFT;
               end else begin
                  cnt <= cnt - 10'd1;
               end
            end
            ST_SHIFT: begin
               if (ctrlMode) begin
                  if (mEdge) begin
                     sclkLvl <= !sclkLvl;
                     if (wordEnd) begin
                        cnt <= 10'(halfLo) + 10'(curT2c) + 10'(HOLD_ADD);
                        st  <= ST_HOLD;
                     end else begin
                        cnt <= sclkLvl ? 10'(halfLo) : 10'(halfHi);
                     end
                  end else begin
                     cnt <= cnt - 10'd1;
                  end
               end else if (wordEnd) begin
                  wbEn <= 1'b1;
                  st   <= ST_IDLE;
               end else if (!csInAct && !firstEdge) begin
                  wbEn    <= 1'b1;
                  wbAbort <= 1'b1;
                  st      <= ST_IDLE;
               end
            end
            ST_HOLD: begin
               if (cnt == 10'd1) begin
                  wbEn <= 1'b1;
                  // keep select when held
                  // release now if nothing follows, so the last hold stays exact
                  csActive <= curHold && (popIf.valid || seqActive);
                  st       <= ST_IDLE;
               end else begin
                  cnt <= cnt - 10'd1;
               end
            end
            default: st <= ST_IDLE;
         endcase
      end
   end

   // pin functions
   always_comb begin
      funcOut[PIN_SCLK] = sclkLvl ^ ((st == ST_IDLE) ? wordFormatSetting[0][FMT_POL_BIT] : pol);
      funcOe[PIN_SCLK]  = ctrlMode;
      funcOut[PIN_SIMO] = shreg[15];
      funcOe[PIN_SIMO]  = ctrlMode;
      funcOut[PIN_SOMI] = shreg[15];
      funcOe[PIN_SOMI]  = !ctrlMode && csInAct;
      funcOut[PIN_CS]   = !csActive;
      funcOe[PIN_CS]    = ctrlMode;
   end

   for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            pinOut[i] <= 1'b0;
            pinOe[i]  <= 1'b0;
         end else begin
            pinOut[i] <= pinGpio[i] ? gpioOutVal[i] : funcOut[i];
            pinOe[i]  <= pinGpio[i] ? gpioOutEn[i] : funcOe[i];
         end
      end
   end

   assign serialClockPinOut       = pinOut[PIN_SCLK];
   assign serialClockPinOe        = pinOe[PIN_SCLK];
   assign controllerOutDataPinOut = pinOut[PIN_SIMO];
   assign controllerOutDataPinOe  = pinOe[PIN_SIMO];
   assign controllerInDataPinOut  = pinOut[PIN_SOMI];
   assign controllerInDataPinOe   = pinOe[PIN_SOMI];
   assign chipSelNPinOut          = pinOut[PIN_CS];
   assign chipSelNPinOe           = pinOe[PIN_CS];

   setupLoad_a:
   assert property (@(posedge mclk) disable iff (rst) (load && ctrlMode) |=>
      (st == ST_SETUP && csActive &&
       cnt == 10'(curC2t) + (curHold ? 10'd3 : 10'd2)))
      else $error("select setup count wrong");

   setupCount_a:
   assert property (@(posedge mclk) disable iff (rst) (st == ST_SETUP && cnt > 10'd1) |=>
      (st == ST_SETUP && cnt == $past(cnt) - 10'd1 && !sclkLvl))
      else $error("setup countdown broken");

   holdLoad_a:
   assert property (@(posedge mclk) disable iff (rst) (st == ST_SHIFT && ctrlMode && wordEnd) |=>
      (st == ST_HOLD && !sclkLvl && csActive &&
       cnt == 10'(halfLo) + 10'(curT2c) + 10'd1))
      else $error("deselect hold count wrong");

   halfPeriod_a:
   assert property (@(posedge mclk) disable iff (rst)
      (st == ST_SHIFT && mEdge && !wordEnd) |=>
      (sclkLvl != $past(sclkLvl) && cnt == (sclkLvl ? 10'(halfHi) : 10'(halfLo))))
      else $error("serial clock half period wrong");

   periodMin_a:
   assert property (@(posedge mclk) disable iff (rst)
      (st == ST_SHIFT) |-> (10'(halfHi) + 10'(halfLo) >= 10'(MIN_SCLK_CYC) &&
      (halfHi == halfLo || halfHi == halfLo + 9'd1)))
      else $error("serial clock period too short");

   captureBit_a:
   assert property (@(posedge mclk) disable iff (rst) isCapture |=>
      (rxShift[0] == $past(inBit) && bitCnt == $past(bitCnt) + 5'd1))
      else $error("capture did not sample input");

   dataStable_a:
   assert property (@(posedge mclk) disable iff (rst) (ctrlMode && isCapture) |->
      ($stable(shreg) && !isLaunch))
      else $error("output data moved at capture");

   wordLength_a:
   assert property (@(posedge mclk) disable iff (rst) wordEnd |->
      (nextBits == curLen && curLen >= 5'd2 && curLen <= 5'd16))
      else $error("word length out of range");

   holdSelect_a:
   assert property (@(posedge mclk) disable iff (rst)
      (st == ST_HOLD && cnt == 10'd1 && curHold) |=> ##1 (st != ST_IDLE || csActive ||
      !seqActive) && !pinOut[PIN_CS] == (csActive || pinGpio[PIN_CS]) || pinGpio[PIN_CS])
      else $error("select dropped between held words");

   groupEnd_a:
   assert property (@(posedge mclk) disable iff (rst)
      (seqActive && pushIf.ready && seqIdx == seqEnd) |=> !seqActive)
      else $error("group walk ran past its end");

   gpioPin_a:
   assert property (@(posedge mclk) disable iff (rst) pinGpio[PIN_SIMO] |=>
      (pinOut[PIN_SIMO] == $past(gpioOutVal[PIN_SIMO]) &&
       pinOe[PIN_SIMO] == $past(gpioOutEn[PIN_SIMO])))
      else $error("general purpose pin not followed");

   clockDrive_a:
   assert property (@(posedge mclk) disable iff (rst) !pinGpio[PIN_SCLK] |=>
      (pinOe[PIN_SCLK] == $past(ctrlMode)))
      else $error("serial clock direction wrong");
endmodule
`default_nettype wire

//--- tb/mbspi_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module mbspi_periph_model (
   // serial lines
   input  wire logic        sclk,
   input  wire logic        csN,
   input  wire logic        simo,
   output logic             somi,
   // word format and data
   input  wire logic        pol,
   input  wire logic        pha,
   input  wire logic [4:0]  len,
   input  wire logic [15:0] txWord,
   output logic [15:0]      rxWord
);
   logic [15:0] sh;
   logic [15:0] rxSh;
   int          n;
   initial somi = 1'b0;
   initial rxWord = 16'h0000;
   always @(negedge csN) begin
      n = 0;
      sh = txWord << (16 - len);
      somi = sh[15];
   end
   // a released line shows the inverse, never the last bit
   always @(posedge csN) somi = ~somi;
   always @(sclk) begin
      if (!csN) begin
         if ((sclk ^ pol) == pha) begin
            if (n == 0) rxSh = 16'h0000;
            rxSh = {rxSh[14:0], simo};
            n++;
            if (n == len) begin
               rxWord = rxSh;
               n = 0;
               #16;
               sh = txWord << (16 - len);
               somi = sh[15];
            end
         end else if (n > 0) begin
            sh = sh << 1;
            somi = sh[15];
         end
      end
   end
endmodule
`default_nettype wire

//--- tb/tb_multibuffer_spi_controller.sv
`timescale 1ns/1ps
`default_nettype none
module tb_multibuffer_spi_controller import mbspi_pkg::*;;
   logic                     mclk, rst, wrEn, gStart, busy;
   logic [15:0]              gcr, dly, wrTx, wrCtrl, mTx, mRx;
   logic [NUM_FMT-1:0][31:0] fmt;
   logic [ADDR_W-1:0]        wrAddr, rdAddr, gFirst, gLast;
   logic [63:0]              rdData;
   logic [NUM_PINS-1:0]      pinGpio, gVal, gEn, gIn, extDrv;
   logic                     sclkO, sclkOe, simoO, simoOe, somiO, somiOe, csO, csOe;
   logic                     modelSomi, mPol, mPha;
   logic [4:0]               mLen;
   logic                     prevSclk = 1'b0;
   logic                     prevCs = 1'b1;
   logic                     seenEdge;
   int                       nFail, checksDone, cyc, csFallT, lastT, gap, prevGap;
   int                       setupCyc, holdCyc, perCyc, csRises;
   // pin levels from the controller's enables, else the bench or the model
   wire logic sclkW = sclkOe ? sclkO : extDrv[0];
   wire logic simoW = simoOe ? simoO : extDrv[1];
   wire logic somiW = somiOe ? somiO : (pinGpio[2] ? extDrv[2] : modelSomi);
   wire logic csW   = csOe ? csO : extDrv[3];

   mbspi_ctrl mbspi_ctrl_inst (.mclk(mclk), .rst(rst), .globalControlSetting(gcr),
      .wordFormatSetting(fmt), .selectDelaySetting(dly), .bufWrEn(wrEn), .bufWrAddr(wrAddr),
      .bufWrTx(wrTx), .bufWrCtrl(wrCtrl), .bufRdAddr(rdAddr), .bufRdData(rdData),
      .groupStart(gStart), .groupFirst(gFirst), .groupLast(gLast), .busy(busy),
      .pinGpio(pinGpio), .gpioOutVal(gVal), .gpioOutEn(gEn), .gpioIn(gIn),
      .serialClockPinIn(sclkW), .serialClockPinOut(sclkO), .serialClockPinOe(sclkOe),
      .controllerOutDataPinIn(simoW), .controllerOutDataPinOut(simoO),
      .controllerOutDataPinOe(simoOe), .controllerInDataPinIn(somiW),
      .controllerInDataPinOut(somiO), .controllerInDataPinOe(somiOe),
      .chipSelNPinIn(csW), .chipSelNPinOut(csO), .chipSelNPinOe(csOe));

   mbspi_periph_model mbspi_periph_model_inst (.sclk(sclkW), .csN(csW), .simo(simoW),
      .somi(modelSomi), .pol(mPol), .pha(mPha), .len(mLen), .txWord(mTx), .rxWord(mRx));

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // edge timing seen on the pins, in whole mclk cycles
   always @(posedge mclk) begin
      cyc++;
      if (prevCs && !csW) begin
         csFallT = cyc;
         seenEdge = 1'b0;
      end
      if (sclkW !== prevSclk && !csW) begin
         if (!seenEdge) setupCyc = cyc - csFallT;
         seenEdge = 1'b1;
         prevGap = gap;
         gap = cyc - lastT;
         lastT = cyc;
         perCyc = gap + prevGap;
      end
      if (!prevCs && csW) begin
         holdCyc = cyc - lastT;
         csRises++;
      end
      prevSclk = sclkW;
      prevCs = csW;
   end

   always @(posedge mclk) if (cyc == 20000) begin
      nFail++;
      stopTest();
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         nFail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] tx, input logic [15:0] c);
      @(negedge mclk);
      wrEn = 1'b1;
      wrAddr = a;
      wrTx = tx;
      wrCtrl = c;
      @(negedge mclk);
      wrEn = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [63:0] d);
      @(negedge mclk);
      rdAddr = a;
      @(negedge mclk);
      d = rdData;
   endtask

   task automatic runGroup(input logic [7:0] f, input logic [7:0] l);
      csRises = 0;
      @(negedge mclk);
      gFirst = f;
      gLast = l;
      gStart = 1'b1;
      @(negedge mclk);
      gStart = 1'b0;
      // busy is registered one cycle behind the group walk
      @(negedge mclk);
      for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(negedge mclk);
   endtask

   task automatic setFmt(input int i, input logic pl, input logic ph, input logic [7:0] ps,
                         input logic [4:0] ln, input logic [15:0] peerTx, input logic [15:0] d);
      @(negedge mclk);
      fmt[i] = {14'h0000, pl, ph, ps, 3'h0, ln};
      dly = d;
      mPol = pl;
      mPha = ph;
      mLen = ln;
      mTx = peerTx;
   endtask

   task automatic wordBasic();
      logic [63:0] d;
      setFmt(0, 1'b0, 1'b0, 8'h09, 5'h08, 16'h003c, 16'h0304);
      wr(8'h00, 16'h00a5, 16'h0000);
      runGroup(8'h00, 8'h00);
      rd(8'h00, d);
      check("clock drive", sclkOe, 1'b1);
      check("peer rx", mRx, 16'h00a5);
      check("buffer rx", d[23:16], 8'h3c);
      check("done", d[48], 1'b1);
      check("setup", setupCyc, 32'h5);
      check("hold", holdCyc, 32'ha);
      check("period", perCyc, 32'ha);
      check("idle clock", sclkW, 1'b0);
   endtask

   task automatic holdPair();
      logic [63:0] d;
      // idle clock level comes from format 0, so match it to the word's polarity
      setFmt(0, 1'b1, 1'b0, 8'h0e, 5'h10, 16'hc3a5, 16'h0201);
      setFmt(1, 1'b1, 1'b0, 8'h0e, 5'h10, 16'hc3a5, 16'h0201);
      wr(8'h02, 16'h9a5c, 16'h0003);
      wr(8'h03, 16'h4e71, 16'h0003);
      runGroup(8'h02, 8'h03);
      rd(8'h02, d);
      check("rx first", d[31:16], 16'hc3a5);
      rd(8'h03, d);
      check("rx second", d[31:16], 16'hc3a5);
      check("peer rx 16", mRx, 16'h4e71);
      check("setup hold", setupCyc, 32'h5);
      check("hold odd", holdCyc, 32'h9);
      check("period odd", perCyc, 32'hf);
      check("select rises", csRises, 32'h1);
      check("idle high", sclkW, 1'b1);
   endtask

   task automatic phaseOne();
      logic [63:0] d;
      // first capture is the leading edge: leave room for the input synchroniser
      setFmt(0, 1'b0, 1'b1, 8'h09, 5'h02, 16'h0001, 16'h0300);
      wr(8'h05, 16'h0002, 16'h0000);
      runGroup(8'h05, 8'h05);
      rd(8'h05, d);
      check("peer rx 2", mRx[1:0], 2'h2);
      check("rx 2 bits", d[17:16], 2'h1);
      check("select rises 1", csRises, 32'h1);
   endtask

   task automatic gpioUse();
      @(negedge mclk);
      pinGpio = 4'h9;
      gEn = 4'h1;
      gVal = 4'h1;
      extDrv = 4'h0;
      repeat (5) @(negedge mclk);
      check("gpio drive", {sclkOe, sclkW}, 2'h3);
      check("gpio in low", gIn[3], 1'b0);
      extDrv = 4'h8;
      repeat (5) @(negedge mclk);
      check("gpio in high", gIn[3], 1'b1);
      pinGpio = 4'h0;
      gEn = 4'h0;
      gcr = 16'h0000;
      repeat (3) @(negedge mclk);
      check("peripheral clock", sclkOe, 1'b0);
   endtask

   task automatic stopTest();
      if (nFail == 0 && checksDone > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      rst = 1'b1;
      gcr = 16'h0001;
      fmt = '0;
      dly = 16'h0000;
      {wrEn, gStart, wrAddr, wrTx, wrCtrl, rdAddr, gFirst, gLast} = '0;
      {pinGpio, gVal, gEn} = '0;
      extDrv = 4'h8;
      {mPol, mPha, mTx} = '0;
      mLen = 5'h08;
      repeat (5) @(negedge mclk);
      rst = 1'b0;
      wordBasic();
      holdPair();
      phaseOne();
      gpioUse();
      stopTest();
   end
endmodule
`default_nettype wire
